/* spwd_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the sleep/regulator/watchdog block
// Assumes: 100 MHz system clock, AXI4-Lite byte addresses in the low 8 bits
// Notes: Included by the package and by both modules
`ifndef SPWD_DEFS_SVH
`define SPWD_DEFS_SVH

// Register byte offsets
`define SPWD_OFF_REGPWR 8'h00
`define SPWD_OFF_WDTCTL 8'h04
`define SPWD_OFF_IRQST 8'h08
`define SPWD_OFF_IRQMSK 8'h0C
`define SPWD_OFF_STATE 8'h10
`define SPWD_OFF_WDTCLR 8'h14

// Field positions
`define SPWD_LPSEL_BIT 1
`define SPWD_RSVD_BIT 0
`define SPWD_WDTPS_LSB 1
`define SPWD_WDTPS_MSB 5
`define SPWD_SWEN_BIT 0
`define SPWD_IRQ_WDT_RST 0
`define SPWD_IRQ_WDT_WAKE 1
`define SPWD_IRQ_RESUME 2
`define SPWD_IRQ_W 3

// Reset values
`define SPWD_LPSEL_RST 1'b0
`define SPWD_WDTPS_RST 5'h0B
`define SPWD_SWEN_RST 1'b0

// Timing
`define SPWD_CLK_PERIOD_NS 10
`define SPWD_SYS_CLK_HZ 100000000
`define SPWD_LF_OSC_HZ 31000
`define SPWD_LF_DIV_CYC ((`SPWD_SYS_CLK_HZ + `SPWD_LF_OSC_HZ - 1) / `SPWD_LF_OSC_HZ)
`define SPWD_STAB_DELAY_NS 5000
`define SPWD_STAB_DELAY_CYC ((`SPWD_STAB_DELAY_NS + `SPWD_CLK_PERIOD_NS - 1) / `SPWD_CLK_PERIOD_NS)
`define SPWD_WDT_BASE_TICKS 24'h000020
`define SPWD_WDT_PS_MAX 5'h12

// Bus responses
`define SPWD_RESP_OKAY 2'h0
`define SPWD_RESP_SLVERR 2'h2

`endif

/* spwd_pkg.sv */
// Purpose: Types and shared decode functions of the sleep/regulator/watchdog block
// Assumes: spwd_defs.svh supplies the numbers
// Notes: State of each module is one packed struct
`include "spwd_defs.svh"

package spwd_pkg;

    typedef enum logic [2:0] {
        SPWD_AWAKE = 3'h1,
        SPWD_SLEEP = 3'h2,
        SPWD_WAKE_DLY = 3'h4
    } spwd_pwr_state_t;

    typedef enum logic [1:0] {
        SPWD_WDT_OFF = 2'h0,
        SPWD_WDT_SW = 2'h1,
        SPWD_WDT_NOSLEEP = 2'h2,
        SPWD_WDT_ON = 2'h3
    } spwd_wdt_mode_t;

    typedef struct packed {
        logic [11:0] lf_div;
        logic lf_tick;
        logic [23:0] cnt;
        logic timeout;
    } spwd_wdt_state_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic lp_sel;
        logic [4:0] wdt_ps;
        logic wdt_sw_en;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        spwd_pwr_state_t pwr;
        logic [9:0] dly_cnt;
        logic lp_used;
        logic hold;
        logic cap_seen;
        logic rst_pulse;
        logic to_n;
        logic pd_n;
        logic reg_lp;
        logic cap_pin_a5;
    } spwd_top_state_t;

    // Watchdog running for a given mode, software enable and sleep state
    function automatic logic spwd_wdt_active(input logic [1:0] mode, input logic sw_en, input logic asleep);
        logic act;
        act = 1'b0;
        unique case (mode)
            SPWD_WDT_ON: act = 1'b1;
            SPWD_WDT_NOSLEEP: act = !asleep;
            SPWD_WDT_SW: act = sw_en;
            SPWD_WDT_OFF: act = 1'b0;
        endcase
        return act;
    endfunction

    // Time-out length in slow-oscillator ticks; out-of-range codes fall back to the shortest
    function automatic logic [23:0] spwd_wdt_limit(input logic [4:0] ps);
        logic [23:0] lim;
        lim = `SPWD_WDT_BASE_TICKS;
        if (ps <= `SPWD_WDT_PS_MAX) begin
            lim = `SPWD_WDT_BASE_TICKS << ps;
        end
        return lim;
    endfunction

endpackage

/* spwd_watchdog.sv */
// Purpose: Watchdog counter timed from a divided slow-oscillator tick
// Assumes: One system clock; the slow oscillator is modelled as an enable pulse
// Notes: Clear and stop both force the count to zero
`timescale 1ns/1ps
`include "spwd_defs.svh"

module spwd_watchdog
    import spwd_pkg::*;
#(
    parameter int LF_DIV_CYC = `SPWD_LF_DIV_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic clear_in,
    input wire logic [4:0] period_sel_in,
    output logic running_out,
    output logic timeout_out
);

    spwd_wdt_state_t st_q;
    spwd_wdt_state_t st_d;

    // Divider runs free, as the slow oscillator is independent of software
    always_comb begin
        st_d = st_q;
        st_d.timeout = 1'b0;
        st_d.lf_tick = (st_q.lf_div == 12'(LF_DIV_CYC - 1));
        st_d.lf_div = st_d.lf_tick ? 12'h000 : st_q.lf_div + 12'h001;
        if (clear_in || !run_in) begin
            st_d.cnt = 24'h000000;
        end else if (st_q.lf_tick) begin
            if (st_q.cnt == spwd_wdt_limit(period_sel_in) - 24'h000001) begin
                st_d.cnt = 24'h000000;
                st_d.timeout = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 24'h000001;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign timeout_out = st_q.timeout;
    assign running_out = run_in;

    property p_wdt_timeout_cause;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        timeout_out |-> $past(st_q.lf_tick) && ($past(st_q.cnt) == spwd_wdt_limit($past(period_sel_in)) - 24'h000001);
    endproperty
    a_wdt_timeout_cause: assert property (p_wdt_timeout_cause) else $error("watchdog timed out early");

    property p_wdt_clear;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        clear_in |=> (st_q.cnt == 24'h000000) && !timeout_out;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog count not cleared");

    property p_wdt_tick_single;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        st_q.lf_tick |=> !st_q.lf_tick;
    endproperty
    a_wdt_tick_single: assert property (p_wdt_tick_single) else $error("slow tick lasted two cycles");

endmodule

/* spwd_top.sv */
// Purpose: Sleep regulator mode, regulator-capacitor power-up hold and watchdog, behind AXI4-Lite
// Assumes: All pin inputs synchronous to ref_clk_in; sleep and wake requests are one-cycle pulses
// Notes: Watchdog time-out while awake resets the device; while asleep it wakes it
// Functional notes
// - With low-power select set, the regulator goes to low power for the whole of Sleep.
// - The low-power select bit is 0 after every reset, giving normal regulator and fast wake.
// - Waking from Sleep in low-power regulator mode adds a stabilisation delay before running.
// - An enabled peripheral that needs the normal regulator keeps it normal in Sleep.
// - Regulator register bits 7..2 read 0, bit 0 reads 1; software writes bit 0 as 1.
// - At power-up the device is held in reset until the regulator capacitor is charged.
// - Cap-pin select 0 puts the regulator capacitor on port A pin five.
// - The watchdog resets the device if not cleared before its time-out.
// - The watchdog counts the 31 kHz slow oscillator with a 1 ms base tick.
// - The time-out ranges from 1 ms to 256 s.
// - Four watchdog modes chosen by a two-bit configuration field.
// - Mode 11 runs always, including Sleep.
// - Mode 10 runs awake and stops in Sleep.
// - Mode 01 runs only while the software enable is 1; mode 00 is off.
// - A time-out in Sleep wakes the device and updates the time-out and power-down flags.
// - The watchdog is cleared on entering Sleep and on waking, and counts in Sleep only if enabled.
`timescale 1ns/1ps
`include "spwd_defs.svh"

module spwd_top
    import spwd_pkg::*;
#(
    parameter int LF_DIV_CYC = `SPWD_LF_DIV_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [31:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    input wire logic [1:0] watchdog_mode_cfg_in,
    input wire logic regulator_cap_pin_select_in,
    input wire logic cap_charged_in,
    input wire logic sleep_enter_in,
    input wire logic wake_event_in,
    input wire logic watchdog_clear_instr_in,
    input wire logic normal_reg_periph_en_in,
    output logic regulator_low_power_out,
    output logic regulator_cap_pin_on_port_a_pin_five_out,
    output logic device_reset_req_out,
    output logic cpu_run_out,
    output logic irq_out
);

    spwd_top_state_t st_q;
    spwd_top_state_t st_d;
    logic wdt_run_c;
    logic wdt_clr_c;
    logic wake_c;
    logic wdt_timeout;

    // Handshake readies are combinational; one write and one read in flight at most
    assign s_axi_awready_out = !st_q.aw_have && !st_q.bvalid;
    assign s_axi_wready_out = !st_q.w_have && !st_q.bvalid;
    assign s_axi_arready_out = !st_q.rvalid;

    always_comb begin
        logic commit;
        logic wr_en;
        logic wr_clr;
        logic [2:0] irq_set;
        logic [2:0] irq_clr;
        logic asleep;
        st_d = st_q;
        commit = st_q.aw_have && st_q.w_have && !st_q.bvalid;
        wr_en = commit && st_q.w_strb[0];
        wr_clr = 1'b0;
        irq_set = 3'h0;
        irq_clr = 3'h0;
        wake_c = 1'b0;
        st_d.rst_pulse = 1'b0;
        asleep = (st_q.pwr == SPWD_SLEEP);
        // Watchdog enable per mode, settled before the state read below uses it
        wdt_run_c = spwd_wdt_active(watchdog_mode_cfg_in, st_q.wdt_sw_en, asleep);

        // Write address and data are accepted in either order
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr_in[7:0];
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata_in;
            st_d.w_strb = s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            st_d.bvalid = 1'b0;
        end
        if (commit) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `SPWD_RESP_OKAY;
            unique case (st_q.aw_addr)
                `SPWD_OFF_REGPWR: begin
                    // Reserved bit 0 is hardwired; a write of 0 there is simply not kept
                    if (wr_en) st_d.lp_sel = st_q.w_data[`SPWD_LPSEL_BIT];
                end
                `SPWD_OFF_WDTCTL: begin
                    if (wr_en) begin
                        st_d.wdt_ps = st_q.w_data[`SPWD_WDTPS_MSB:`SPWD_WDTPS_LSB];
                        st_d.wdt_sw_en = st_q.w_data[`SPWD_SWEN_BIT];
                    end
                end
                `SPWD_OFF_IRQST: begin
                    if (wr_en) irq_clr = st_q.w_data[2:0];
                end
                `SPWD_OFF_IRQMSK: begin
                    if (wr_en) st_d.irq_mask = st_q.w_data[2:0];
                end
                `SPWD_OFF_WDTCLR: begin
                    if (wr_en) wr_clr = st_q.w_data[0];
                end
                `SPWD_OFF_STATE: begin
                end
                default: st_d.bresp = `SPWD_RESP_SLVERR;
            endcase
        end

        // Read mux; unmapped addresses answer SLVERR with zero data
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `SPWD_RESP_OKAY;
            st_d.rdata = 32'h00000000;
            unique case (s_axi_araddr_in[7:0])
                `SPWD_OFF_REGPWR: begin
                    st_d.rdata[`SPWD_LPSEL_BIT] = st_q.lp_sel;
                    st_d.rdata[`SPWD_RSVD_BIT] = 1'b1;
                end
                `SPWD_OFF_WDTCTL: begin
                    st_d.rdata[`SPWD_WDTPS_MSB:`SPWD_WDTPS_LSB] = st_q.wdt_ps;
                    st_d.rdata[`SPWD_SWEN_BIT] = st_q.wdt_sw_en;
                end
                `SPWD_OFF_IRQST: st_d.rdata[2:0] = st_q.irq_st;
                `SPWD_OFF_IRQMSK: st_d.rdata[2:0] = st_q.irq_mask;
                `SPWD_OFF_STATE: begin
                    st_d.rdata[7:0] = {st_q.cap_pin_a5, st_q.pd_n, st_q.to_n, wdt_run_c, st_q.hold,
                                       st_q.pwr == SPWD_WAKE_DLY, st_q.reg_lp, asleep};
                end
                `SPWD_OFF_WDTCLR: begin
                end
                default: st_d.rresp = `SPWD_RESP_SLVERR;
            endcase
        end

        // Power-up hold: two consecutive charged samples end it
        st_d.cap_seen = cap_charged_in;
        if (st_q.hold && st_q.cap_seen && cap_charged_in) begin
            st_d.hold = 1'b0;
        end

        // Watchdog clear by instruction or by the register strobe
        if (watchdog_clear_instr_in || wr_clr) begin
            st_d.to_n = 1'b1;
            st_d.pd_n = 1'b1;
        end

        // Sleep sequencing
        unique case (st_q.pwr)
            SPWD_AWAKE: begin
                if (sleep_enter_in && !st_q.hold && !wdt_timeout) begin
                    st_d.pwr = SPWD_SLEEP;
                    st_d.pd_n = 1'b0;
                    st_d.to_n = 1'b1;
                    st_d.lp_used = 1'b0;
                end
            end
            SPWD_SLEEP: begin
                if (st_q.reg_lp) st_d.lp_used = 1'b1;
                if (wdt_timeout) begin
                    st_d.to_n = 1'b0;
                    irq_set[`SPWD_IRQ_WDT_WAKE] = 1'b1;
                end
                if (wdt_timeout || wake_event_in) begin
                    wake_c = 1'b1;
                    if (st_q.lp_used || st_q.reg_lp) begin
                        st_d.pwr = SPWD_WAKE_DLY;
                        st_d.dly_cnt = 10'(`SPWD_STAB_DELAY_CYC - 1);
                    end else begin
                        st_d.pwr = SPWD_AWAKE;
                        irq_set[`SPWD_IRQ_RESUME] = 1'b1;
                    end
                end
            end
            SPWD_WAKE_DLY: begin
                if (st_q.dly_cnt == 10'h000) begin
                    st_d.pwr = SPWD_AWAKE;
                    irq_set[`SPWD_IRQ_RESUME] = 1'b1;
                end else begin
                    st_d.dly_cnt = st_q.dly_cnt - 10'h001;
                end
            end
            default: st_d.pwr = SPWD_AWAKE;
        endcase

        // Time-out while awake resets the device and its regulator and watchdog control bits; the IRQ mask keeps its value
        if (wdt_timeout && !asleep) begin
            st_d.rst_pulse = 1'b1;
            st_d.to_n = 1'b0;
            st_d.pwr = SPWD_AWAKE;
            st_d.lp_sel = `SPWD_LPSEL_RST;
            st_d.wdt_ps = `SPWD_WDTPS_RST;
            st_d.wdt_sw_en = `SPWD_SWEN_RST;
            irq_set[`SPWD_IRQ_WDT_RST] = 1'b1;
        end

        // Regulator low power only in Sleep and only if no peripheral needs it normal
        st_d.reg_lp = (st_d.pwr == SPWD_SLEEP) && st_d.lp_sel && !normal_reg_periph_en_in;
        st_d.cap_pin_a5 = !regulator_cap_pin_select_in;

        // Set wins over a clear in the same cycle
        st_d.irq_st = (st_q.irq_st & ~irq_clr) | irq_set;

        // Watchdog clear on the events that restart it
        wdt_clr_c = st_q.hold || watchdog_clear_instr_in || wr_clr || wake_c ||
                    (st_q.pwr == SPWD_AWAKE && st_d.pwr == SPWD_SLEEP);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
            st_q.pwr <= SPWD_AWAKE;
            st_q.lp_sel <= `SPWD_LPSEL_RST;
            st_q.wdt_ps <= `SPWD_WDTPS_RST;
            st_q.wdt_sw_en <= `SPWD_SWEN_RST;
            st_q.hold <= 1'b1;
            st_q.to_n <= 1'b1;
            st_q.pd_n <= 1'b1;
            st_q.cap_pin_a5 <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    spwd_watchdog #(
        .LF_DIV_CYC(LF_DIV_CYC)
    ) u_watchdog (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .run_in(wdt_run_c),
        .clear_in(wdt_clr_c),
        .period_sel_in(st_q.wdt_ps),
        .running_out(),
        .timeout_out(wdt_timeout)
    );

    assign s_axi_bvalid_out = st_q.bvalid;
    assign s_axi_bresp_out = st_q.bresp;
    assign s_axi_rvalid_out = st_q.rvalid;
    assign s_axi_rdata_out = st_q.rdata;
    assign s_axi_rresp_out = st_q.rresp;
    assign regulator_low_power_out = st_q.reg_lp;
    assign regulator_cap_pin_on_port_a_pin_five_out = st_q.cap_pin_a5;
    assign device_reset_req_out = st_q.hold || st_q.rst_pulse;
    assign cpu_run_out = (st_q.pwr == SPWD_AWAKE) && !st_q.hold;
    assign irq_out = |(st_q.irq_st & st_q.irq_mask);

    property p_lp_in_sleep;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_q.pwr == SPWD_SLEEP && !wake_c && st_q.lp_sel && !normal_reg_periph_en_in) |=> regulator_low_power_out;
    endproperty
    a_lp_in_sleep: assert property (p_lp_in_sleep) else $error("regulator not in low power during sleep");

    property p_lpsel_reset;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (wdt_timeout && st_q.pwr != SPWD_SLEEP) |=> !st_q.lp_sel && device_reset_req_out;
    endproperty
    a_lpsel_reset: assert property (p_lpsel_reset) else $error("low-power select survived reset");

    property p_wake_delay;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_q.pwr == SPWD_SLEEP && wake_c && st_q.reg_lp && !wdt_timeout) |=> !cpu_run_out [*8];
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("resumed without stabilisation delay");

    property p_periph_normal;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        normal_reg_periph_en_in |=> !regulator_low_power_out;
    endproperty
    a_periph_normal: assert property (p_periph_normal) else $error("low power while peripheral needs normal");

    property p_regpwr_read;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:0] == `SPWD_OFF_REGPWR)
            |=> s_axi_rvalid_out && (s_axi_rdata_out[31:2] == 30'h00000000) && s_axi_rdata_out[0];
    endproperty
    a_regpwr_read: assert property (p_regpwr_read) else $error("regulator register read wrong");

    property p_hold_release;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(st_q.hold) |-> $past(cap_charged_in, 1) && $past(cap_charged_in, 2);
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold released without two charged samples");

    property p_hold_reset;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        st_q.hold |-> device_reset_req_out && !cpu_run_out;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("device not held in reset");

    property p_cap_pin;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !regulator_cap_pin_select_in |=> regulator_cap_pin_on_port_a_pin_five_out;
    endproperty
    a_cap_pin: assert property (p_cap_pin) else $error("cap pin not on port A pin five");

    property p_sleep_timeout_wakes;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (wdt_timeout && st_q.pwr == SPWD_SLEEP) |=> !device_reset_req_out && !st_q.to_n && st_q.pwr != SPWD_SLEEP;
    endproperty
    a_sleep_timeout_wakes: assert property (p_sleep_timeout_wakes) else $error("sleep time-out did not wake");

    property p_nosleep_mode;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (watchdog_mode_cfg_in == SPWD_WDT_NOSLEEP && st_q.pwr == SPWD_SLEEP && $past(st_q.pwr) == SPWD_SLEEP)
            |-> !wdt_timeout;
    endproperty
    a_nosleep_mode: assert property (p_nosleep_mode) else $error("watchdog fired in sleep in mode 10");

endmodule

/* spwd_top_tb.sv */
// Purpose: Self-checking bench for the sleep regulator, power-up hold and watchdog block
// Assumes: Slow tick shortened to 4 cycles, so period select 0 times out after 128 cycles
// Notes: Register traffic over AXI4-Lite; every wait is bounded
`timescale 1ns/1ps
`include "spwd_defs.svh"
module spwd_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
    logic [1:0] mode = 2'h0;
    logic cap = 1'b0, slp = 1'b0, wake = 1'b0, clr = 1'b0, per = 1'b0, csel = 1'b0;
    logic awr, wrdy, bv, arr, rv, reg_lp, pin5, rq, run, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdat;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    spwd_top #(.LF_DIV_CYC(4)) u_spwd_top (.ref_clk_in(clk), .rstn_in(rstn), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
        .watchdog_mode_cfg_in(mode), .regulator_cap_pin_select_in(csel), .cap_charged_in(cap),
        .sleep_enter_in(slp), .wake_event_in(wake), .watchdog_clear_instr_in(clr),
        .normal_reg_periph_en_in(per), .regulator_low_power_out(reg_lp),
        .regulator_cap_pin_on_port_a_pin_five_out(pin5), .device_reset_req_out(rq), .cpu_run_out(run),
        .irq_out(irq));
    // Single value comparison, counted
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Write: both channels offered together, each dropped once taken; readies sampled before the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, done;
        int k;
        done = 1'b0;
        k = 0;
        @(posedge clk);
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wrdy;
            done = (bv === 1'b1);
            if (done) chk({30'h0, bresp}, {30'h0, er});
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            k++;
            if (k > 50) begin
                err_total++;
                $display("ERROR %0t write answer timed out", $time);
                final_report();
            end
        end
        br <= 1'b0;
    endtask
    // Read: address held until taken, data compared on the falling edge before the edge that takes it
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, done;
        int k;
        done = 1'b0;
        k = 0;
        @(posedge clk);
        ara <= {24'h0, a};
        arv <= 1'b1;
        rr <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = arv && arr;
            done = (rv === 1'b1);
            if (done) chk(rdat, e);
            if (done) chk({30'h0, rresp}, {30'h0, er});
            @(posedge clk);
            if (ta) arv <= 1'b0;
            k++;
            if (k > 50) begin
                err_total++;
                $display("ERROR %0t read answer timed out", $time);
                final_report();
            end
        end
        rr <= 1'b0;
    endtask
    // One-cycle pulse: 0 sleep, 1 wake, 2 watchdog clear
    task automatic pulse(input int k);
        @(posedge clk);
        slp <= (k == 0);
        wake <= (k == 1);
        clr <= (k == 2);
        @(posedge clk);
        slp <= 1'b0;
        wake <= 1'b0;
        clr <= 1'b0;
    endtask
    // Bounded wait for reset request (k=1) or running (k=2); a must-wait running out ends the run
    task automatic wt(input int k, input int lim, input bit must, output int cnt);
        logic hit;
        hit = 1'b0;
        cnt = 0;
        while (!hit && cnt < lim) begin
            @(negedge clk);
            hit = (k == 1) ? (rq === 1'b1) : (run === 1'b1);
            cnt++;
        end
        // Return on a rising edge so that following stimulus changes there
        @(posedge clk);
        if (!hit && must) begin
            err_total++;
            $display("ERROR %0t wait ran out", $time);
            final_report();
        end
    endtask
    initial begin
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        cap <= 1'b1;
        repeat (2) begin
            @(negedge clk);
            chk(rq, 1);
        end
        @(negedge clk);
        chk(rq, 0);
        chk(run, 1);
        chk(pin5, 1);
        @(posedge clk);
        csel <= 1'b1;
        repeat (2) @(negedge clk);
        chk(pin5, 0);
        @(posedge clk);
        csel <= 1'b0;
        rd(`SPWD_OFF_REGPWR, 32'h1, 2'h0);
        rd(`SPWD_OFF_WDTCTL, 32'h16, 2'h0);
        wr(`SPWD_OFF_REGPWR, 32'h1, 2'h0);
        rd(`SPWD_OFF_REGPWR, 32'h1, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(`SPWD_OFF_IRQMSK, 32'h7, 2'h0);
        wr(`SPWD_OFF_REGPWR, 32'h3, 2'h0);
        rd(`SPWD_OFF_REGPWR, 32'h3, 2'h0);
        // Low-power sleep, a normal-regulator peripheral overriding it, then the slow wake
        pulse(0);
        repeat (3) @(negedge clk);
        chk({reg_lp, run}, 2'b10);
        @(posedge clk);
        per <= 1'b1;
        repeat (3) @(negedge clk);
        chk(reg_lp, 0);
        @(posedge clk);
        per <= 1'b0;
        repeat (3) @(negedge clk);
        chk(reg_lp, 1);
        pulse(1);
        wt(2, 700, 1, n);
        chk(n >= 490 && n <= 510, 1);
        chk(irq, 1);
        wr(`SPWD_OFF_IRQMSK, 32'h3, 2'h0);
        chk(irq, 0);
        wr(`SPWD_OFF_IRQMSK, 32'h7, 2'h0);
        rd(`SPWD_OFF_IRQST, 32'h4, 2'h0);
        wr(`SPWD_OFF_IRQST, 32'h4, 2'h0);
        chk(irq, 0);
        // Normal regulator in sleep gives the fast wake
        wr(`SPWD_OFF_REGPWR, 32'h1, 2'h0);
        pulse(0);
        pulse(1);
        wt(2, 20, 1, n);
        chk(n <= 3, 1);
        wr(`SPWD_OFF_IRQST, 32'h7, 2'h0);
        // Watchdog modes: software enable off, on, mode off, then mode 11 kept alive by clears until it times out
        wr(`SPWD_OFF_WDTCTL, 32'h0, 2'h0);
        mode <= 2'h1;
        wt(1, 300, 0, n);
        chk(n, 300);
        wr(`SPWD_OFF_WDTCTL, 32'h1, 2'h0);
        wt(1, 300, 1, n);
        rd(`SPWD_OFF_IRQST, 32'h1, 2'h0);
        rd(`SPWD_OFF_WDTCTL, 32'h16, 2'h0);
        wr(`SPWD_OFF_IRQST, 32'h7, 2'h0);
        wr(`SPWD_OFF_WDTCTL, 32'h1, 2'h0);
        mode <= 2'h0;
        wt(1, 300, 0, n);
        chk(n, 300);
        mode <= 2'h3;
        wr(`SPWD_OFF_WDTCTL, 32'h0, 2'h0);
        repeat (4) begin
            wt(1, 80, 0, n);
            chk(n, 80);
            pulse(2);
        end
        wt(1, 300, 1, n);
        // Mode 10 sleeps undisturbed; mode 11 time-out in sleep wakes without reset
        mode <= 2'h2;
        pulse(0);
        wr(`SPWD_OFF_WDTCTL, 32'h0, 2'h0);
        wt(2, 300, 0, n);
        chk(n, 300);
        pulse(1);
        wt(2, 20, 1, n);
        mode <= 2'h3;
        pulse(0);
        wr(`SPWD_OFF_IRQST, 32'h7, 2'h0);
        wt(2, 300, 1, n);
        rd(`SPWD_OFF_IRQST, 32'h6, 2'h0);
        rd(`SPWD_OFF_STATE, 32'h90, 2'h0);
        wr(`SPWD_OFF_WDTCLR, 32'h1, 2'h0);
        rd(`SPWD_OFF_STATE, 32'hF0, 2'h0);
        mode <= 2'h0;
        final_report();
    end
endmodule
